// ### rtl/arg_pkg.sv
// Constants and types shared by the analog ramp generator files.
package arg_pkg;
   localparam int unsigned ARG_CLK_HZ      = 125_000_000;
   localparam int unsigned ARG_TICK_MS     = 100;
   localparam int unsigned ARG_TICK_CYCLES = ARG_CLK_HZ / 1000 * ARG_TICK_MS;
   localparam int          ARG_TICK_W      = 24;
   localparam int          ARG_LW          = 18;
   localparam int          ARG_DW          = 24;
   localparam int          ARG_GW          = 10;
   localparam int          ARG_LANES       = 4;
   localparam int          ARG_LANE_W      = 8;

   typedef logic signed [ARG_LW-1:0] arg_lvl_t;
   typedef logic [14:0]              arg_out_t;
   typedef enum logic [2:0] {S_IDLE, S_LAUNCH, S_RAMP, S_DECEL, S_PARK, S_LOCK} arg_state_e;

   // Register byte addresses.
   localparam logic [5:0] ARG_REG_FIRST  = 6'h00;
   localparam logic [5:0] ARG_REG_SECOND = 6'h04;
   localparam logic [5:0] ARG_REG_CEIL   = 6'h08;
   localparam logic [5:0] ARG_REG_LAUNCH = 6'h0c;
   localparam logic [5:0] ARG_REG_RATE   = 6'h10;
   localparam logic [5:0] ARG_REG_GAIN   = 6'h14;
   localparam logic [5:0] ARG_REG_OFFSET = 6'h18;
   localparam logic [5:0] ARG_REG_LEVEL  = 6'h1c;
   localparam logic [5:0] ARG_REG_SCALED = 6'h20;
   localparam logic [5:0] ARG_REG_STATUS = 6'h24;

   // Status register field positions.
   localparam int ARG_STAT_PH_W = 3;
   localparam int ARG_STAT_EN   = 4;
   localparam int ARG_STAT_SEL  = 5;
   localparam int ARG_STAT_STOP = 6;

   // Setting limits, gain in hundredths.
   localparam arg_lvl_t ARG_LVL_MIN  = -18'sh2710;
   localparam arg_lvl_t ARG_LVL_MAX  = 18'sh4e20;
   localparam arg_lvl_t ARG_OFS_MAX  = 18'sh2710;
   localparam arg_lvl_t ARG_ZERO     = 18'sh0;
   localparam arg_lvl_t ARG_RATE_MIN = 18'sh1;
   localparam arg_lvl_t ARG_RATE_MAX = 18'sh2710;
   localparam arg_lvl_t ARG_GAIN_MAX = 18'sh3e8;
   localparam arg_lvl_t ARG_RATE_DIV = 18'sh0a;
   localparam logic [ARG_DW-1:0] ARG_GAIN_SCALE = 24'h64;
   localparam arg_out_t ARG_OUT_MAX  = 15'h7fff;
   localparam logic [4:0] ARG_DIV_LAST = 5'h17;

   // Reset values of settings.
   localparam arg_lvl_t ARG_RST_RATE = 18'sh64;
   localparam arg_lvl_t ARG_RST_GAIN = 18'sh64;
endpackage : arg_pkg

// ### rtl/arg_ramp.sv
// Analog ramp generator core with its Avalon-MM register slave.
//
// Function
// RL1 - Enable rising loads launch level, holds one 100 ms tick, then ramps.
// RL2 - Enable falling forces the level to the offset at once.
// RL3 - Select low aims at first target, select high at second.
// RL4 - Select change ramps smoothly from present level to new target.
// RL5 - Stop rising ramps to launch level, holds 100 ms, then drops to offset.
// RL6 - After a stop, no restart until stop and enable are both low.
// RL7 - Both targets are signed settings limited to -10000 .. +20000.
// RL8 - Level never exceeds the ceiling setting, range -10000 .. +20000.
// RL9 - Launch level is offset plus launch offset, the latter 0 .. +20000.
// RL10 - Rate is steps per second, 1 .. 10000, for every approach.
// RL11 - Gain ranges 0 .. 10.00, offset ranges -10000 .. +10000.
// RL12 - Output is level minus offset divided by gain, 0 .. 32767.
// RL13 - Level moves and holds are timed only on the 100 ms tick.
// RL14 - Each tick moves one tenth of the rate, landing exactly on target.
// RL15 - Output saturates to 0 .. 32767, also when gain is zero.
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module arg_ramp #(
   parameter int unsigned TICK_CYCLES = arg_pkg::ARG_TICK_CYCLES
) (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              enableIn,
   input  wire logic              selectIn,
   input  wire logic              decelHaltInput,
   input  wire logic [5:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest,
   output arg_pkg::arg_lvl_t      currentLevel,
   output logic [15:0]            scaledAnalogOut
);
   import arg_pkg::*;

   typedef struct packed {
      arg_state_e            phase;
      logic                  prevEn;
      logic                  prevStop;
      logic [ARG_TICK_W-1:0] tickCnt;
      logic                  tick;
      arg_lvl_t              level;
      arg_lvl_t              firstTargetLevel;
      arg_lvl_t              secondTargetLevel;
      arg_lvl_t              levelCeiling;
      arg_lvl_t              launchLevelOffset;
      arg_lvl_t              rate;
      arg_lvl_t              gain;
      arg_lvl_t              offset;
      logic                  waitReq;
      logic [31:0]           rdata;
      logic [15:0]           scaled;
   } arg_core_s;

   localparam arg_core_s CORE_RST = '{
      phase:        S_IDLE,
      waitReq:      1'b1,
      levelCeiling: ARG_LVL_MAX,
      rate:         ARG_RST_RATE,
      gain:         ARG_RST_GAIN,
      default:      '0
   };

   arg_core_s          s;
   arg_core_s          next_s;
   logic               enRise;
   logic               enFall;
   logic               stopRise;
   arg_lvl_t           launchSum;
   arg_lvl_t           launchLvl;
   arg_lvl_t           targetRaw;
   arg_lvl_t           target;
   arg_lvl_t           stepRaw;
   arg_lvl_t           step;
   arg_lvl_t           levelDiff;
   arg_out_t           scalerOut;
   logic [31:0]        beMask;
   logic [31:0]        rdMux;
   logic signed [31:0] wrWord;

   function automatic arg_lvl_t arg_clamp(logic signed [31:0] v, arg_lvl_t lo, arg_lvl_t hi);
      if (v < 32'(lo)) begin
         return lo;
      end else if (v > 32'(hi)) begin
         return hi;
      end
      return ARG_LW'(v);
   endfunction : arg_clamp

   // Moves by at most one step and stops on the goal instead of passing it.
   function automatic arg_lvl_t arg_approach(arg_lvl_t cur, arg_lvl_t goal, arg_lvl_t stp);
      if (cur < goal) begin
         return (goal - cur > stp) ? cur + stp : goal;
      end
      return (cur - goal > stp) ? cur - stp : goal;
   endfunction : arg_approach

   for (genvar i = 0; i < ARG_LANES; i++) begin : g_lane
      assign beMask[ARG_LANE_W*i +: ARG_LANE_W] = {ARG_LANE_W{avs_byteenable[i]}};
   end

   assign enRise    = enableIn & ~s.prevEn;
   assign enFall    = ~enableIn & s.prevEn;
   assign stopRise  = decelHaltInput & ~s.prevStop;
   assign launchSum = s.offset + s.launchLevelOffset; // RL9
   assign launchLvl = (launchSum > s.levelCeiling) ? s.levelCeiling : launchSum; // RL8
   assign targetRaw = selectIn ? s.secondTargetLevel : s.firstTargetLevel; // RL3
   assign target    = (targetRaw > s.levelCeiling) ? s.levelCeiling : targetRaw; // RL8
   assign stepRaw   = s.rate / ARG_RATE_DIV; // RL14
   assign step      = (stepRaw < ARG_RATE_MIN) ? ARG_RATE_MIN : stepRaw; // RL10
   assign levelDiff = s.level - s.offset; // RL12

   assign avs_readdata    = s.rdata;
   assign avs_waitrequest = s.waitReq;
   assign currentLevel    = s.level;
   assign scaledAnalogOut = s.scaled;

   arg_scaler u_scaler (
      .core_clk  (core_clk),
      .rst       (rst),
      .ce        (ce),
      .levelDiff (levelDiff),
      .gain      (s.gain),
      .scaled    (scalerOut)
   );

   always_comb begin
      next_s = s;
      rdMux  = '0;
      if (avs_address == ARG_REG_FIRST) begin
         rdMux = 32'(s.firstTargetLevel);
      end else if (avs_address == ARG_REG_SECOND) begin
         rdMux = 32'(s.secondTargetLevel);
      end else if (avs_address == ARG_REG_CEIL) begin
         rdMux = 32'(s.levelCeiling);
      end else if (avs_address == ARG_REG_LAUNCH) begin
         rdMux = 32'(s.launchLevelOffset);
      end else if (avs_address == ARG_REG_RATE) begin
         rdMux = 32'(s.rate);
      end else if (avs_address == ARG_REG_GAIN) begin
         rdMux = 32'(s.gain);
      end else if (avs_address == ARG_REG_OFFSET) begin
         rdMux = 32'(s.offset);
      end else if (avs_address == ARG_REG_LEVEL) begin
         rdMux = 32'(s.level);
      end else if (avs_address == ARG_REG_SCALED) begin
         rdMux = 32'(s.scaled);
      end else if (avs_address == ARG_REG_STATUS) begin
         rdMux[ARG_STAT_PH_W-1:0] = s.phase;
         rdMux[ARG_STAT_EN]       = enableIn;
         rdMux[ARG_STAT_SEL]      = selectIn;
         rdMux[ARG_STAT_STOP]     = decelHaltInput;
      end
      wrWord = signed'((rdMux & ~beMask) | (avs_writedata & beMask));

      // One wait cycle per request, then a single cycle with waitrequest low.
      if (!s.waitReq) begin
         next_s.waitReq = 1'b1;
      end else if (avs_read || avs_write) begin
         next_s.waitReq = 1'b0;
         next_s.rdata   = rdMux;
      end

      // Writes land where the master sees waitrequest low; values are limited.
      if (!s.waitReq && avs_write) begin
         if (avs_address == ARG_REG_FIRST) begin
            next_s.firstTargetLevel = arg_clamp(wrWord, ARG_LVL_MIN, ARG_LVL_MAX); // RL7
         end else if (avs_address == ARG_REG_SECOND) begin
            next_s.secondTargetLevel = arg_clamp(wrWord, ARG_LVL_MIN, ARG_LVL_MAX); // RL7
         end else if (avs_address == ARG_REG_CEIL) begin
            next_s.levelCeiling = arg_clamp(wrWord, ARG_LVL_MIN, ARG_LVL_MAX); // RL8
         end else if (avs_address == ARG_REG_LAUNCH) begin
            next_s.launchLevelOffset = arg_clamp(wrWord, ARG_ZERO, ARG_LVL_MAX); // RL9
         end else if (avs_address == ARG_REG_RATE) begin
            next_s.rate = arg_clamp(wrWord, ARG_RATE_MIN, ARG_RATE_MAX); // RL10
         end else if (avs_address == ARG_REG_GAIN) begin
            next_s.gain = arg_clamp(wrWord, ARG_ZERO, ARG_GAIN_MAX); // RL11
         end else if (avs_address == ARG_REG_OFFSET) begin
            next_s.offset = arg_clamp(wrWord, -ARG_OFS_MAX, ARG_OFS_MAX); // RL11
         end
      end

      // Update tick.
      next_s.tick = 1'b0;
      if (s.tickCnt == ARG_TICK_W'(TICK_CYCLES - 1)) begin
         next_s.tickCnt = '0;
         next_s.tick    = 1'b1; // RL13
      end else begin
         next_s.tickCnt = s.tickCnt + 1'b1;
      end

      next_s.prevEn   = enableIn;
      next_s.prevStop = decelHaltInput;

      case (s.phase)
         S_IDLE: begin
            next_s.level = s.offset;
            if (enRise) begin
               next_s.level = launchLvl; // RL1
               next_s.phase = S_LAUNCH;
            end
         end
         S_LAUNCH: begin
            if (s.tick) begin
               next_s.phase = S_RAMP; // RL1
            end
         end
         S_RAMP: begin
            if (s.tick) begin
               next_s.level = arg_approach(s.level, target, step); // RL4
            end
         end
         S_DECEL: begin
            if (s.level == launchLvl) begin
               next_s.phase = S_PARK; // RL5
            end else if (s.tick) begin
               next_s.level = arg_approach(s.level, launchLvl, step); // RL5
            end
         end
         S_PARK: begin
            if (s.tick) begin
               next_s.level = s.offset; // RL5
               next_s.phase = S_LOCK;
            end
         end
         S_LOCK: begin
            next_s.level = s.offset;
            if (!enableIn && !decelHaltInput) begin
               next_s.phase = S_IDLE; // RL6
            end
         end
         default: begin
            next_s.phase = S_IDLE;
         end
      endcase

      if (stopRise) begin
         if (s.phase == S_LAUNCH || s.phase == S_RAMP) begin
            next_s.phase = S_DECEL; // RL5
         end else if (s.phase == S_IDLE) begin
            next_s.level = s.offset;
            next_s.phase = S_LOCK; // RL6
         end
      end

      if (enFall) begin
         next_s.level = s.offset; // RL2
         if (stopRise || s.phase == S_DECEL || s.phase == S_PARK || s.phase == S_LOCK) begin
            next_s.phase = S_LOCK; // RL6
         end else begin
            next_s.phase = S_IDLE;
         end
      end

      if (next_s.level > next_s.levelCeiling) begin
         next_s.level = next_s.levelCeiling; // RL8
      end

      next_s.scaled = {1'b0, scalerOut}; // RL12
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s <= CORE_RST;
      end else if (ce) begin
         s <= next_s;
      end
   end

   level_below_ceiling_a: assert property ( // RL8
      @(posedge core_clk) disable iff (rst)
      s.level <= s.levelCeiling)
      else $error("Level is above the ceiling.");

   enable_drop_a: assert property ( // RL2
      @(posedge core_clk) disable iff (rst)
      ce && enFall && !avs_write && s.offset <= s.levelCeiling |=> s.level == $past(s.offset))
      else $error("Enable fall did not force the offset level.");

   launch_start_a: assert property ( // RL1
      @(posedge core_clk) disable iff (rst)
      ce && s.phase == S_IDLE && enRise && !stopRise && !avs_write
      |=> s.phase == S_LAUNCH && s.level == $past(launchLvl))
      else $error("Enable rise did not load the launch level.");

   launch_hold_a: assert property ( // RL13
      @(posedge core_clk) disable iff (rst)
      ce && s.phase == S_LAUNCH && !s.tick && !enFall && !stopRise && !avs_write
      |=> s.phase == S_LAUNCH && $stable(s.level))
      else $error("Launch level left before the tick.");

   ramp_step_a: assert property ( // RL14
      @(posedge core_clk) disable iff (rst)
      ce && s.phase == S_RAMP && s.tick && !enFall && !stopRise && !avs_write
      |=> (s.level - $past(s.level) <= $past(step)) && ($past(s.level) - s.level <= $past(step)))
      else $error("Ramp moved by more than one step.");

   first_target_a: assert property ( // RL3
      @(posedge core_clk) disable iff (rst)
      ce && s.phase == S_RAMP && s.tick && !selectIn && !enFall && !stopRise && !avs_write
      && s.level == s.firstTargetLevel |=> s.level == $past(s.firstTargetLevel))
      else $error("Ramp left the first target level.");

   lock_hold_a: assert property ( // RL6
      @(posedge core_clk) disable iff (rst)
      ce && s.phase == S_LOCK && (enableIn || decelHaltInput) |=> s.phase == S_LOCK)
      else $error("Restart allowed while stop or enable is high.");

   park_release_a: assert property ( // RL5
      @(posedge core_clk) disable iff (rst)
      ce && s.phase == S_PARK && s.tick && !enFall && !avs_write && s.offset <= s.levelCeiling
      |=> s.phase == S_LOCK && s.level == $past(s.offset))
      else $error("Stop hold did not end at the offset level.");

   target_range_a: assert property ( // RL7
      @(posedge core_clk) disable iff (rst)
      s.secondTargetLevel >= ARG_LVL_MIN && s.secondTargetLevel <= ARG_LVL_MAX)
      else $error("Second target outside its range.");

   bus_wait_a: assert property (
      @(posedge core_clk) disable iff (rst)
      ce && !avs_waitrequest |=> avs_waitrequest)
      else $error("Waitrequest low for more than one cycle.");
endmodule : arg_ramp
`default_nettype wire

// ### rtl/arg_scaler.sv
// Sequential divider that scales the ramp level to the analog output word.
`timescale 1ns/1ns
`default_nettype none
module arg_scaler (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire arg_pkg::arg_lvl_t levelDiff,
   input  wire arg_pkg::arg_lvl_t gain,
   output arg_pkg::arg_out_t      scaled
);
   import arg_pkg::*;

   typedef struct packed {
      logic              busy;
      logic [4:0]        cnt;
      logic [ARG_GW-1:0] rem;
      logic [ARG_DW-1:0] dvd;
      logic [ARG_DW-1:0] quo;
      logic [ARG_GW-1:0] dvs;
      arg_out_t          res;
   } arg_div_s;

   arg_div_s          d;
   arg_div_s          next_d;
   logic [ARG_GW:0]   trial;
   logic [ARG_DW-1:0] quoNew;

   assign scaled = d.res;

   // Restoring division, one quotient bit per cycle; the dividend carries the
   // factor of one hundred that the hundredths gain needs.
   always_comb begin
      next_d = d;
      trial  = {d.rem, d.dvd[ARG_DW-1]};
      quoNew = {d.quo[ARG_DW-2:0], 1'b0};
      if (!d.busy) begin
         if (levelDiff <= ARG_ZERO) begin
            next_d.res = '0; // RL15
         end else if (gain == ARG_ZERO) begin
            next_d.res = ARG_OUT_MAX; // RL15
         end else begin
            next_d.busy = 1'b1;
            next_d.cnt  = '0;
            next_d.rem  = '0;
            next_d.quo  = '0;
            next_d.dvs  = gain[ARG_GW-1:0];
            next_d.dvd  = ARG_DW'(levelDiff) * ARG_GAIN_SCALE; // RL12
         end
      end else begin
         if (trial >= {1'b0, d.dvs}) begin
            next_d.rem = ARG_GW'(trial - {1'b0, d.dvs});
            quoNew[0]  = 1'b1;
         end else begin
            next_d.rem = trial[ARG_GW-1:0];
         end
         next_d.quo = quoNew;
         next_d.dvd = {d.dvd[ARG_DW-2:0], 1'b0};
         next_d.cnt = d.cnt + 1'b1;
         if (d.cnt == ARG_DIV_LAST) begin
            next_d.busy = 1'b0;
            if (quoNew > ARG_DW'(ARG_OUT_MAX)) begin
               next_d.res = ARG_OUT_MAX; // RL15
            end else begin
               next_d.res = quoNew[$bits(arg_out_t)-1:0]; // RL12
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         d <= '0;
      end else if (ce) begin
         d <= next_d;
      end
   end
endmodule : arg_scaler
`default_nettype wire

// ### test/arg_ctrl_model.sv
// Model of the logic that drives the enable, select and stop lines of the ramp.
`timescale 1ns/1ns
`default_nettype none
module arg_ctrl_model (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic wantEn,
   input  wire logic wantSel,
   input  wire logic wantStop,
   input  wire logic rude,
   output logic      enableIn,
   output logic      selectIn,
   output logic      decelHaltInput
);
   logic stopSeen;
   // After a stop, enable may fall but not rise until both lines were low; rude skips that.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         enableIn       <= 1'b0;
         selectIn       <= 1'b0;
         decelHaltInput <= 1'b0;
         stopSeen       <= 1'b0;
      end else begin
         selectIn       <= wantSel;
         decelHaltInput <= wantStop;
         if (wantStop) begin
            stopSeen <= 1'b1;
         end else if (!wantEn) begin
            stopSeen <= 1'b0;
         end
         enableIn <= (stopSeen && !rude) ? (enableIn & wantEn) : wantEn;
      end
   end
endmodule : arg_ctrl_model
`default_nettype wire

// ### test/arg_ramp_tb.sv
// Self-checking testbench of the analog ramp generator.
`timescale 1ns/1ns
`default_nettype none
module arg_ramp_tb;
   import arg_pkg::*;
   localparam int TICK_C = 40;
   logic              core_clk;
   logic              rst;
   logic              wantEn;
   logic              wantSel;
   logic              wantStop;
   logic              rude;
   logic              ce;
   logic              enableIn;
   logic              selectIn;
   logic              decelHaltInput;
   logic [5:0]        avs_address;
   logic              avs_read;
   logic              avs_write;
   logic [31:0]       avs_writedata;
   logic [3:0]        avs_byteenable;
   logic [31:0]       avs_readdata;
   logic              avs_waitrequest;
   arg_lvl_t          currentLevel;
   logic [15:0]       scaledAnalogOut;
   int                miscompares;
   int                check_count;

   arg_ctrl_model ctl (.core_clk(core_clk), .rst(rst), .wantEn(wantEn), .wantSel(wantSel),
      .wantStop(wantStop), .rude(rude), .enableIn(enableIn), .selectIn(selectIn),
      .decelHaltInput(decelHaltInput));

   arg_ramp #(.TICK_CYCLES(TICK_C)) dut (.core_clk(core_clk), .rst(rst), .ce(ce),
      .enableIn(enableIn), .selectIn(selectIn), .decelHaltInput(decelHaltInput),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .currentLevel(currentLevel),
      .scaledAnalogOut(scaledAnalogOut));

   always #4 core_clk = ~core_clk;

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   // One Avalon transfer; the request stands until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [5:0] a, input int d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= 32'(d);
      avs_write     <= wr;
      avs_read      <= !wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (n >= 50) begin
         check(1'b0, 1'b1, "bus timeout");
         wrap_up();
      end
   endtask : bus

   task automatic wr(input logic [5:0] a, input int d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd_chk(input logic [5:0] a, input int exp);
      logic [31:0] q;
      bus(1'b0, a, 0, q);
      check(q, 32'(exp), "register read");
   endtask : rd_chk

   // Waits a bounded time for level or output to reach v; n returns the cycles taken.
   task automatic wait_v(input bit lvl, input int v, input int lim, output int n);
      n = 0;
      while ((lvl ? 32'(currentLevel) : 32'(scaledAnalogOut)) !== 32'(v) && n < lim) begin
         @(posedge core_clk);
         n++;
      end
      check(lvl ? 32'(currentLevel) : 32'(scaledAnalogOut), 32'(v), "wait value");
      if (n >= lim) begin
         wrap_up();
      end
   endtask : wait_v

   task automatic t_regs();
      logic [5:0] a[10] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h1c,
                           6'h20, 6'h24};
      int         e[10] = '{0, 0, 20000, 0, 100, 100, 0, 0, 0, 0};
      for (int i = 0; i < 10; i++) begin
         rd_chk(a[i], e[i]);
      end
      wr(6'h28, 5);
      rd_chk(6'h28, 0);
      wr(ARG_REG_LEVEL, 5);
      rd_chk(ARG_REG_LEVEL, 0);
      // A write with only the low lane enabled keeps the other lanes of the old value.
      avs_byteenable <= 4'h1;
      wr(ARG_REG_RATE, 32'h1234);
      avs_byteenable <= 4'hf;
      rd_chk(ARG_REG_RATE, 32'h34);
   endtask : t_regs

   task automatic t_clamp();
      logic [5:0] a[8] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h10, 6'h14, 6'h18};
      int         w[8] = '{30000, -20000, -11000, -5, 0, 20000, 2000, -20000};
      int         e[8] = '{20000, -10000, -10000, 0, 1, 10000, 1000, -10000};
      for (int i = 0; i < 8; i++) begin
         wr(a[i], w[i]);
         rd_chk(a[i], e[i]);
      end
   endtask : t_clamp

   task automatic t_launch();
      int n;
      wr(ARG_REG_CEIL, 20000);
      wr(ARG_REG_OFFSET, 100);
      wr(ARG_REG_LAUNCH, 50);
      wr(ARG_REG_FIRST, 300);
      wr(ARG_REG_SECOND, 100);
      wr(ARG_REG_RATE, 1000);
      wr(ARG_REG_GAIN, 100);
      wait_v(1'b1, 100, 4, n);
      wantEn <= 1'b1;
      wait_v(1'b1, 150, 6, n);
      wait_v(1'b1, 250, 2 * TICK_C + 6, n);
      wait_v(1'b1, 300, TICK_C + 6, n);
      check(32'(n), 32'(TICK_C), "tick spacing");
      wait_v(1'b0, 200, 60, n);
      repeat (TICK_C + 4) @(posedge core_clk);
      check(32'(currentLevel), 32'(300), "no overshoot");
   endtask : t_launch

   task automatic t_select();
      int n;
      wantSel <= 1'b1;
      wait_v(1'b1, 200, TICK_C + 6, n);
      wait_v(1'b1, 100, TICK_C + 6, n);
      wantSel <= 1'b0;
      wait_v(1'b1, 200, TICK_C + 6, n);
      wait_v(1'b1, 300, TICK_C + 6, n);
   endtask : t_select

   task automatic t_stop();
      int n;
      int enStop;
      enStop = (1 << ARG_STAT_EN) + (1 << ARG_STAT_STOP);
      wantStop <= 1'b1;
      wait_v(1'b1, 200, TICK_C + 6, n);
      rd_chk(ARG_REG_STATUS, int'(S_DECEL) + enStop);
      wait_v(1'b1, 150, TICK_C + 6, n);
      wait_v(1'b1, 100, 2 * TICK_C + 6, n);
      check(32'(n), 32'(TICK_C), "park hold");
      wantEn <= 1'b0;
      repeat (3) @(posedge core_clk);
      rude   <= 1'b1;
      wantEn <= 1'b1;
      repeat (2 * TICK_C) @(posedge core_clk);
      check(32'(currentLevel), 32'(100), "restart refused");
      rd_chk(ARG_REG_STATUS, int'(S_LOCK) + enStop);
      wantEn   <= 1'b0;
      wantStop <= 1'b0;
      rude     <= 1'b0;
      repeat (4) @(posedge core_clk);
      wantEn <= 1'b1;
      wait_v(1'b1, 150, 6, n);
   endtask : t_stop

   task automatic t_drop();
      int n;
      wait_v(1'b1, 250, 2 * TICK_C + 6, n);
      wantEn <= 1'b0;
      wait_v(1'b1, 100, 4, n);
      wait_v(1'b0, 0, 60, n);
      wr(ARG_REG_CEIL, 120);
      wantEn <= 1'b1;
      wait_v(1'b1, 120, 6, n);
      repeat (3 * TICK_C) @(posedge core_clk);
      check(32'(currentLevel), 32'(120), "ceiling held");
      wr(ARG_REG_GAIN, 50);
      wait_v(1'b0, 40, 60, n);
      wr(ARG_REG_GAIN, 0);
      wait_v(1'b0, 32767, 60, n);
      // With the clock enable low the enable fall must wait until the clock enable returns.
      ce     <= 1'b0;
      wantEn <= 1'b0;
      repeat (TICK_C + 4) @(posedge core_clk);
      check(32'(currentLevel), 32'(120), "frozen by clock enable");
      ce <= 1'b1;
      wait_v(1'b1, 100, 4, n);
      // A stop that rises while idle locks the block at once.
      wantStop <= 1'b1;
      repeat (2) @(posedge core_clk);
      rd_chk(ARG_REG_STATUS, int'(S_LOCK) + (1 << ARG_STAT_STOP));
      wantStop <= 1'b0;
   endtask : t_drop

   initial begin
      core_clk      = 1'b0;
      rst           = 1'b1;
      wantEn        = 1'b0;
      wantSel       = 1'b0;
      wantStop      = 1'b0;
      rude          = 1'b0;
      ce            = 1'b1;
      avs_address   = 6'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      miscompares   = 0;
      check_count   = 0;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      t_regs();
      t_clamp();
      t_launch();
      t_select();
      t_stop();
      t_drop();
      wrap_up();
   end
endmodule : arg_ramp_tb
`default_nettype wire
